/* testbench/serial_peer.sv */
// Serial peer: frame decoder on txd, frame sender on rxd
`timescale 1ns/1ps
module serial_peer (
	// Serial lines
	input wire txd,
	output reg rxd
);
	real        bit_ns = 4000.0 / 3.0;
	integer     nbits = 8;
	realtime    t_fall = 0;
	realtime    lo_ns = 0;
	logic [7:0] got[$];
	logic [7:0] b;
	initial rxd = 1'b1;
	// Low span of a frame up to its first rise
	always @(negedge txd) t_fall = $realtime;
	always @(posedge txd) lo_ns = $realtime - t_fall;
	// Mid-bit sampling, LSB first, stop must be high
	always @(negedge txd) begin
		#(bit_ns * 1.5);
		b = 8'h00;
		for (int i = 0; i < nbits; i++) begin
			b[i] = txd;
			#(bit_ns);
		end
		if (txd === 1'b1)
			got.push_back(b);
	end
	task automatic send(input logic [7:0] d);
		rxd = 1'b0;
		#(bit_ns);
		for (int i = 0; i < 8; i++) begin
			rxd = d[i];
			#(bit_ns);
		end
		rxd = 1'b1;
		#(bit_ns);
	endtask
	task automatic brk(input integer n);
		rxd = 1'b0;
		#(bit_ns * n);
		rxd = 1'b1;
		#(bit_ns);
	endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the bridged serial core
`timescale 1ns/1ps
`include "uart_core_defs.vh"
module testbench;
	reg          ref_clk = 1'b0;
	reg          rst = 1'b1;
	reg  [3:0]   reg_addr = 4'h0;
	reg  [31:0]  reg_wdata = 32'h0;
	reg          reg_wr = 1'b0;
	reg          reg_rd = 1'b0;
	reg          sof_pulse = 1'b0;
	reg          usb_suspend = 1'b0;
	reg  [7:0]   pin_ext = 8'h00;
	reg  [3:0]   cfg_ext = 4'hf;
	wire [31:0]  reg_rdata;
	wire [7:0]   port_in, port_out, port_oe, port_drive_high;
	wire [3:0]   config_pins_in, config_pins_out, config_pins_oe;
	wire         suspend_active, peer_rxd;
	wire [7:0]   pin_mix = {pin_ext[7:2], peer_rxd, pin_ext[0]};
	integer      n_fail = 0;
	integer      checks_done = 0;
	integer      k, lows;
	logic [31:0] q;
	logic        s;
	logic [31:0] bauds[4] = '{32'h20, 32'h24, 32'h0b, 32'h17};
	real         divs[4] = '{4.0, 4.5, 1.0, 2.875};
	always #4 ref_clk = ~ref_clk;
	assign port_in = (port_oe & port_out) | (~port_oe & pin_mix);
	assign config_pins_in = (config_pins_oe & config_pins_out)
		| (~config_pins_oe & cfg_ext);
	always @(negedge ref_clk) if (config_pins_out[0] === 1'b0) lows++;
	usb_bridged_uart_core i_usb_bridged_uart_core (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sof_pulse(sof_pulse),
		.usb_suspend(usb_suspend), .port_in(port_in),
		.port_out(port_out), .port_oe(port_oe),
		.port_drive_high(port_drive_high),
		.config_pins_in(config_pins_in),
		.config_pins_out(config_pins_out),
		.config_pins_oe(config_pins_oe),
		.suspend_active(suspend_active));
	serial_peer peer (.txd(port_out[0]), .rxd(peer_rxd));
	// ----
	// Bus and check tasks
	// ----
	task automatic cyc(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic wait_rx(input integer n);
		for (k = 0; k < 30000 && peer.got.size() < n; k++)
			@(posedge ref_clk);
	endtask
	task automatic toggles(output integer n);
		logic last;
		n = 0;
		last = config_pins_out[3];
		repeat (100) begin
			@(negedge ref_clk);
			if (config_pins_out[3] !== last)
				n++;
			last = config_pins_out[3];
		end
	endtask
	task automatic wait_port(input logic [7:0] v);
		for (k = 0; k < 2000 && port_out !== v; k++)
			@(negedge ref_clk);
		chk(port_out, v);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#600000;
		n_fail++;
		report_and_stop();
	end
	// ----
	// Tests
	// ----
	initial begin
		cyc(2);
		rst <= 1'b0;
		#1;
		chk(port_out[0], 1);
		rd(`REG_BAUD);
		chk(q, {15'h0, `BAUD_RESET});
		rd(4'hf);
		chk(q, 32'h0);
		$display("test reset done");
		foreach (bauds[i]) begin
			peer.bit_ns = 1000.0 / 3.0 * divs[i];
			wr(`REG_BAUD, bauds[i]);
			wr(`REG_TXDATA, 32'h0);
			wait_rx(1);
			chk(peer.lo_ns > 8.5 * peer.bit_ns
				&& peer.lo_ns < 9.5 * peer.bit_ns, 1);
			peer.got.delete();
		end
		$display("test divisor done");
		wr(`REG_PINCFG, 32'hc6c);
		peer.bit_ns = 4000.0 / 3.0;
		wr(`REG_BAUD, 32'h20);
		wr(`REG_TXDATA, 32'h55);
		wr(`REG_TXDATA, 32'ha3);
		cyc(60);
		chk(config_pins_out[2], 1);
		wait_rx(2);
		chk(peer.got[0], 8'h55);
		chk(peer.got[1], 8'ha3);
		cyc(200);
		chk(config_pins_out[2], 0);
		wr(`REG_CTRL, 32'h1);
		peer.nbits = 7;
		peer.got.delete();
		wr(`REG_TXDATA, 32'h2a);
		wait_rx(1);
		chk(peer.got[0], 8'h2a);
		peer.nbits = 8;
		peer.got.delete();
		wr(`REG_CTRL, 32'h2);
		@(posedge ref_clk) pin_ext <= 8'h08;
		cyc(4);
		wr(`REG_TXDATA, 32'h66);
		cyc(2000);
		chk(peer.got.size(), 0);
		chk(port_out[2], 0);
		@(posedge ref_clk) pin_ext <= 8'h00;
		wait_rx(1);
		chk(peer.got[0], 8'h66);
		wr(`REG_CTRL, 32'h0);
		$display("test transmit done");
		peer.send(8'h3c);
		peer.send(8'hc3);
		cyc(20);
		rd(`REG_STATUS);
		chk(q[19:10], 10'd2);
		rd(`REG_RXDATA);
		chk(q, 32'h13c);
		rd(`REG_RXDATA);
		chk(q, 32'h1c3);
		rd(`REG_RXDATA);
		chk(q[8], 0);
		$display("test receive done");
		wr(`REG_CTRL, 32'h10);
		cyc(4);
		chk(port_out[0], 0);
		wr(`REG_CTRL, 32'h0);
		peer.brk(12);
		cyc(20);
		rd(`REG_STATUS);
		chk(q[9], 1);
		wr(`REG_STATUS, 32'h0);
		rd(`REG_STATUS);
		chk(q[9], 0);
		wr(`REG_INVERT, 32'h1);
		chk(port_out[0], 0);
		wr(`REG_INVERT, 32'h0);
		wr(`REG_DRIVE, 32'h5a);
		chk(port_drive_high, 8'h5a);
		$display("test break done");
		s = config_pins_out[0];
		@(posedge ref_clk) sof_pulse <= 1'b1;
		@(posedge ref_clk) sof_pulse <= 1'b0;
		cyc(4);
		chk(config_pins_out[0], {~s});
		toggles(k);
		chk(k >= 8 && k <= 11, 1);
		@(posedge ref_clk) usb_suspend <= 1'b1;
		cyc(8);
		chk(suspend_active, 1);
		chk(config_pins_out[1], 0);
		toggles(k);
		chk(k, 0);
		@(posedge ref_clk) usb_suspend <= 1'b0;
		cyc(8);
		chk(config_pins_out[1], 1);
		wr(`REG_PINCFG, 32'hc7c);
		@(posedge ref_clk);
		cfg_ext <= 4'hd;
		usb_suspend <= 1'b1;
		cyc(8);
		chk(suspend_active, 0);
		usb_suspend <= 1'b0;
		cfg_ext <= 4'hf;
		$display("test config pins done");
		wr(`REG_PINCFG, 32'h2);
		wr(`REG_CTRL, 32'h20);
		chk(port_oe, 8'hff);
		lows = 0;
		wr(`REG_TXDATA, 32'ha5);
		wr(`REG_TXDATA, 32'h3c);
		wait_port(8'ha5);
		wait_port(8'h3c);
		cyc(200);
		chk(lows, 6);
		$display("test bit-bang done");
		wr(`REG_CTRL, 32'h40);
		repeat (16) rd(`REG_RXDATA);
		chk(q[8], 0);
		wr(`REG_TXDATA, 32'h81);
		wr(`REG_TXDATA, 32'h42);
		wait_port(8'h42);
		cyc(4);
		rd(`REG_RXDATA);
		chk(q, 32'h13c);
		rd(`REG_RXDATA);
		chk(q, 32'h181);
		rd(`REG_RXDATA);
		chk(q[8], 0);
		$display("test sync bit-bang done");
		report_and_stop();
	end
endmodule

/* testbench/uart_core_sva.sv */
// Port-level assertions for the bridged serial core
`timescale 1ns/1ps
`include "uart_core_defs.vh"
module uart_core_chk (
	// Clock and reset
	input wire        ref_clk,
	input wire        rst,
	// Register port
	input wire [3:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	// Events and pins
	input wire        sof_pulse,
	input wire        usb_suspend,
	input wire [7:0]  port_oe,
	input wire [7:0]  port_drive_high,
	input wire [3:0]  config_pins_out,
	input wire [3:0]  config_pins_oe,
	input wire        suspend_active
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_reset_vals;
		$fell(rst) |-> port_oe == 8'h15 && config_pins_oe == 4'h0;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("pin enables wrong after reset");
	property p_rd_quiet;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet)
		else $error("read data outside its answer cycle");
	property p_oe_legal;
		port_oe == 8'h15 || port_oe == 8'hff;
	endproperty
	a_oe_legal: assert property (p_oe_legal)
		else $error("port enables neither serial nor bit-bang");
	property p_oe_cause;
		$changed(port_oe) |-> $past(reg_wr) && $past(reg_addr) == `REG_CTRL;
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("port enables changed without a mode write");
	property p_drive_cause;
		$changed(port_drive_high)
			|-> $past(reg_wr) && $past(reg_addr) == `REG_DRIVE;
	endproperty
	a_drive_cause: assert property (p_drive_cause)
		else $error("drive strength changed without a write");
	property p_cfgoe_cause;
		$changed(config_pins_oe)
			|-> $past(reg_wr) && $past(reg_addr) == `REG_PINCFG;
	endproperty
	a_cfgoe_cause: assert property (p_cfgoe_cause)
		else $error("config pin enables changed without a write");
	property p_susp_cause;
		suspend_active |-> usb_suspend;
	endproperty
	a_susp_cause: assert property (p_susp_cause)
		else $error("suspend entered without bus suspend");
	property p_susp_still;
		(suspend_active && !sof_pulse && !reg_wr && !reg_rd)[*4]
			|-> $stable(config_pins_out);
	endproperty
	a_susp_still: assert property (p_susp_still)
		else $error("config pin moved during suspend");
endmodule
bind usb_bridged_uart_core uart_core_chk i_uart_core_chk (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sof_pulse(sof_pulse), .usb_suspend(usb_suspend),
	.port_oe(port_oe), .port_drive_high(port_drive_high),
	.config_pins_out(config_pins_out),
	.config_pins_oe(config_pins_oe),
	.suspend_active(suspend_active)
);

/* verilog/byte_fifo.v */
// Byte FIFO with first-word-fall-through read
`timescale 1ns/1ps
module byte_fifo #(
	parameter DEPTH_W = 9
) (
	// Clock and reset
	input  wire               ref_clk,
	input  wire               rst,
	// Write side
	input  wire               wr_valid,
	output wire               wr_ready,
	input  wire [7:0]         wr_data,
	// Read side
	output wire               rd_valid,
	input  wire               rd_ready,
	output wire [7:0]         rd_data,
	output wire [DEPTH_W:0]   level
);
	reg [7:0]         mem [0:(1<<DEPTH_W)-1];
	reg [DEPTH_W:0]   wp_q;
	reg [DEPTH_W:0]   rp_q;
	wire              do_wr;
	wire              do_rd;

	assign level    = wp_q - rp_q;
	assign wr_ready = (level[DEPTH_W] == 1'b0);
	assign rd_valid = (wp_q != rp_q);
	assign rd_data  = mem[rp_q[DEPTH_W-1:0]];
	assign do_wr    = wr_valid & wr_ready;
	assign do_rd    = rd_valid & rd_ready;

	always @(posedge ref_clk) begin
		if (do_wr)
			mem[wp_q[DEPTH_W-1:0]] <= wr_data;
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp_q <= {(DEPTH_W+1){1'b0}};
			rp_q <= {(DEPTH_W+1){1'b0}};
		end else begin
			if (do_wr)
				wp_q <= wp_q + 1'b1;
			if (do_rd)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule

/* verilog/uart_core_defs.vh */
// Constants for the bridged serial core
`ifndef UART_CORE_DEFS_VH
`define UART_CORE_DEFS_VH

// Register indices (byte address = index * 4)
`define REG_CTRL        4'h0
`define REG_BAUD        4'h1
`define REG_STATUS      4'h2
`define REG_TXDATA      4'h3
`define REG_RXDATA      4'h4
`define REG_BBANG       4'h5
`define REG_PINCFG      4'h6
`define REG_INVERT      4'h7
`define REG_XCHAR       4'h8
`define REG_DRIVE       4'h9

// Control field positions
`define CTRL_BITS7      0
`define CTRL_RTSCTS     1
`define CTRL_DTRDSR     2
`define CTRL_XONXOFF    3
`define CTRL_BREAK      4
`define CTRL_MODE_LO    5
`define CTRL_MODE_HI    6
`define CTRL_RTS        7
`define CTRL_DTR        8

// Operating modes
`define MODE_UART       2'h0
`define MODE_ABB        2'h1
`define MODE_SBB        2'h2

// Configurable pin functions
`define PIN_TRI         3'h0
`define PIN_LINE_DRIVER_ENABLE       3'h1
`define PIN_WRSTB       3'h2
`define PIN_RDSTB       3'h3
`define PIN_SOF         3'h4
`define PIN_SLEEP       3'h5
`define PIN_CLK6        3'h6
`define PIN_KEEPAWAKE   3'h7

// Baud generator
`define BAUD_RESET      17'h00068
`define FRAC_W          3
`define INT_W           14

// Flow control
`define XON_RESET       8'h11
`define XOFF_RESET      8'h13
`define RTS_HIGH_MARK   10'd480
`define RTS_LOW_MARK    10'd256

`endif

/* verilog/usb_bridged_uart_core.v */
// Serial side of a USB-to-serial bridge
//
// Functional notes
// - Baud generator makes a sixteen-times bit clock from the 48 MHz reference.
// - Divisor is a 14-bit integer prescaler plus a 3-bit fraction.
// - Bit rate is 3000000 / (n + x), n from 2 to 16383.
// - Fraction x is one of eight eighths, 0 through 0.875.
// - Integer 1 only with zero fraction; no divisor between 1 and 2.
// - Serial conversion with 7 or 8 data bits.
// - Host bytes queue in a 512-byte FIFO feeding the transmit shifter.
// - Received characters queue in a 512-byte FIFO drained by the host.
// - Modem lines RTS, CTS, DSR, DTR, DCD and RI are provided.
// - RTS/CTS, DTR/DSR and XON/XOFF flow control run in hardware.
// - A config pin can show line_driver_enable while transmitting.
// - Transmit line can be forced to BREAK; receive BREAK is detected.
// - Each serial signal has its own inversion and drive strength setting.
// - Async bit-bang drives queued bytes to an 8-bit port at prescaler rate.
// - Bit-bang modes pulse read and write strobes on config pins.
// - Sync bit-bang samples the port only when a byte is written.
// - Frame toggle pin inverts on each start-of-frame packet.
// - Held suspend_inhibit_n keeps the device out of suspend.
// - Clock outputs on config pins stop during suspend.
// - The ref_clk reference (REF_HZ, 125 MHz default) clocks FIFO control and protocol logic.
// - Clock unit makes 48, 24, 12 and 6 MHz; 48 MHz feeds the baud generator.
// - Internal logic resets at power-up and on the reset input.
// - Suspend indicator pin is low throughout USB suspend unless suspend_inhibit_n is held.
`timescale 1ns/1ps
`include "uart_core_defs.vh"
module usb_bridged_uart_core #(
	parameter REF_HZ  = 125000000,
	parameter FIFO_AW = 9
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// Register port
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// USB engine events
	input  wire        sof_pulse,
	input  wire        usb_suspend,
	// Serial and bit-bang port pins
	input  wire [7:0]  port_in,
	output wire [7:0]  port_out,
	output wire [7:0]  port_oe,
	output wire [7:0]  port_drive_high,
	// Configurable pins
	input  wire [3:0]  config_pins_in,
	output reg  [3:0]  config_pins_out,
	output reg  [3:0]  config_pins_oe,
	// Power state
	output wire        suspend_active
);
	// Port bit order: 0 txd 1 rxd 2 rts 3 cts 4 dtr 5 dsr 6 dcd 7 ri
	localparam [7:0] UART_OE = 8'h15;
	// 48 MHz tick accumulator step, scaled to ref_clk
	localparam [31:0] STEP48 = 48000000 / 1000;
	localparam [31:0] REF_K  = REF_HZ / 1000;

	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------
	reg [7:0] pin_s1_q, pin_s2_q;
	reg [3:0] cfg_s1_q, cfg_s2_q;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s1_q <= 8'hff;
			pin_s2_q <= 8'hff;
			cfg_s1_q <= 4'hf;
			cfg_s2_q <= 4'hf;
		end else begin
			pin_s1_q <= port_in;
			pin_s2_q <= pin_s1_q;
			cfg_s1_q <= config_pins_in;
			cfg_s2_q <= cfg_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	reg [8:0]  ctrl_q;
	reg [16:0] baud_q;
	reg [11:0] pincfg_q;
	reg [7:0]  invert_q;
	reg [7:0]  drive_q;
	reg [7:0]  xon_q, xoff_q;
	reg [7:0]  bb_out_q;
	reg        brk_seen_q;
	wire [1:0] mode = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
	wire [7:0] pins = pin_s2_q ^ invert_q;
	wire       keep_awake;

	// FIFO handshakes
	wire       hf_valid, rf_ready, rf_valid;
	wire [7:0] hf_data, rf_data;
	wire [FIFO_AW:0] rf_level;
	reg        hf_pop, rf_push;
	reg [7:0]  rf_wdata;

	wire wr_tx  = reg_wr & (reg_addr == `REG_TXDATA);
	wire rd_rx  = reg_rd & (reg_addr == `REG_RXDATA);

	// Baud fields, with the divisor floored at legal values
	wire [13:0] div_int  = baud_q[16:3];
	wire [2:0]  div_frac = baud_q[2:0];
	wire        div_low  = (div_int < 14'd2);
	// Divisor in eighths; n=0/1 fall back to 1.0, fraction dropped
	wire [16:0] div8 = div_low ? 17'd8 : {div_int, div_frac};

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q   <= 9'h000;
			baud_q   <= `BAUD_RESET;
			pincfg_q <= 12'h000;
			invert_q <= 8'h00;
			drive_q  <= 8'h00;
			xon_q    <= `XON_RESET;
			xoff_q   <= `XOFF_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
			`REG_CTRL:   ctrl_q   <= reg_wdata[8:0];
			`REG_BAUD:   baud_q   <= reg_wdata[16:0];
			`REG_PINCFG: pincfg_q <= reg_wdata[11:0];
			`REG_INVERT: invert_q <= reg_wdata[7:0];
			`REG_DRIVE:  drive_q  <= reg_wdata[7:0];
			`REG_XCHAR: begin
				xon_q  <= reg_wdata[7:0];
				xoff_q <= reg_wdata[15:8];
			end
			default: ;
			endcase
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd) begin
			case (reg_addr)
			`REG_CTRL:   reg_rdata <= {23'h0, ctrl_q};
			`REG_BAUD:   reg_rdata <= {15'h0, baud_q};
			`REG_STATUS: reg_rdata <= {{(21-FIFO_AW){1'b0}}, rf_level,
				brk_seen_q, usb_suspend, 3'b000, pins[7:4], 1'b0};
			`REG_RXDATA: reg_rdata <= {23'h0, rf_valid, rf_data};
			`REG_BBANG:  reg_rdata <= {24'h0, bb_out_q};
			`REG_PINCFG: reg_rdata <= {20'h0, pincfg_q};
			`REG_INVERT: reg_rdata <= {24'h0, invert_q};
			`REG_XCHAR:  reg_rdata <= {16'h0, xoff_q, xon_q};
			`REG_DRIVE:  reg_rdata <= {24'h0, drive_q};
			default:     reg_rdata <= 32'h0000_0000;
			endcase
		end else
			reg_rdata <= 32'h0000_0000;
	end
	assign port_drive_high = drive_q;

	// ---------------------------------------------------------------
	// FIFOs
	// ---------------------------------------------------------------
	byte_fifo #(.DEPTH_W(FIFO_AW)) host_fifo (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.wr_valid (wr_tx),
		.wr_ready (),
		.wr_data  (reg_wdata[7:0]),
		.rd_valid (hf_valid),
		.rd_ready (hf_pop),
		.rd_data  (hf_data),
		.level    ()
	);
	byte_fifo #(.DEPTH_W(FIFO_AW)) rx_fifo (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.wr_valid (rf_push),
		.wr_ready (rf_ready),
		.wr_data  (rf_wdata),
		.rd_valid (rf_valid),
		.rd_ready (rd_rx),
		.rd_data  (rf_data),
		.level    (rf_level)
	);

	// ---------------------------------------------------------------
	// Baud generator: 48 MHz ticks, then fractional 16x divide
	// ---------------------------------------------------------------
	reg [31:0] acc48_q;
	reg [19:0] bacc_q;
	reg        tick16_q;
	wire [31:0] acc48_n = acc48_q + STEP48;
	wire tick48 = (acc48_n >= REF_K);
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc48_q  <= 32'h0;
			bacc_q   <= 20'h0;
			tick16_q <= 1'b0;
		end else begin
			acc48_q  <= tick48 ? acc48_n - REF_K : acc48_n;
			tick16_q <= 1'b0;
			// 48 MHz/16 = 3 MHz; each 16x tick every (n+x) * 1 cycle of 48/1
			if (tick48) begin
				if ({3'h0, bacc_q[16:0]} + 20'd8 >= {3'h0, div8}) begin
					bacc_q   <= bacc_q + 20'd8 - {3'h0, div8};
					tick16_q <= 1'b1;
				end else
					bacc_q <= bacc_q + 20'd8;
			end
		end
	end

	// ---------------------------------------------------------------
	// Flow control
	// ---------------------------------------------------------------
	reg rts_q, xoff_hold_q;
	wire cts_ok = ~ctrl_q[`CTRL_RTSCTS] | ~pins[3];
	wire dsr_ok = ~ctrl_q[`CTRL_DTRDSR] | ~pins[5];
	wire tx_allowed = cts_ok & dsr_ok & ~xoff_hold_q;
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			rts_q <= 1'b1;
		else if (rf_level >= `RTS_HIGH_MARK)
			rts_q <= 1'b0;
		else if (rf_level <= `RTS_LOW_MARK)
			rts_q <= 1'b1;
	end

	// ---------------------------------------------------------------
	// Transmitter, 16 ticks per bit
	// ---------------------------------------------------------------
	reg [3:0] tdiv_q;
	reg [3:0] tbit_q;
	reg [8:0] tsh_q;
	reg       tbusy_q;
	wire [3:0] tlast = ctrl_q[`CTRL_BITS7] ? 4'd8 : 4'd9;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tdiv_q  <= 4'h0;
			tbit_q  <= 4'h0;
			tsh_q   <= 9'h1ff;
			tbusy_q <= 1'b0;
		end else if (mode != `MODE_UART) begin
			tbusy_q <= 1'b0;
			tsh_q   <= 9'h1ff;
		end else if (!tbusy_q) begin
			if (hf_valid && tx_allowed && tick16_q) begin
				tsh_q   <= {hf_data[7] | ctrl_q[`CTRL_BITS7],
					hf_data[6:0], 1'b0};
				tbusy_q <= 1'b1;
				tdiv_q  <= 4'h0;
				tbit_q  <= 4'h0;
			end
		end else if (tick16_q) begin
			tdiv_q <= tdiv_q + 4'h1;
			if (tdiv_q == 4'hf) begin
				tsh_q  <= {1'b1, tsh_q[8:1]};
				tbit_q <= tbit_q + 4'h1;
				if (tbit_q == tlast)
					tbusy_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Receiver, mid-bit sampling
	// ---------------------------------------------------------------
	reg [3:0] rdiv_q;
	reg [3:0] rbit_q;
	reg [7:0] rsh_q;
	reg       rbusy_q, rzero_q;
	wire rxd = pins[1];
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdiv_q <= 4'h0;
			rbit_q <= 4'h0;
			rsh_q  <= 8'h00;
			rbusy_q <= 1'b0;
			rzero_q <= 1'b0;
			xoff_hold_q <= 1'b0;
			brk_seen_q  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `REG_STATUS)
				brk_seen_q <= 1'b0;
			if (mode != `MODE_UART)
				rbusy_q <= 1'b0;
			else if (!rbusy_q) begin
				if (tick16_q && !rxd) begin
					rbusy_q <= 1'b1;
					rdiv_q  <= 4'h0;
					rbit_q  <= 4'h0;
					rzero_q <= 1'b1;
				end
			end else if (tick16_q) begin
				rdiv_q <= rdiv_q + 4'h1;
				if (rdiv_q == 4'h7) begin
					rbit_q <= rbit_q + 4'h1;
					if (rxd)
						rzero_q <= 1'b0;
					if (rbit_q == 4'h0 && rxd)
						rbusy_q <= 1'b0;
					else if (rbit_q == tlast) begin
						rbusy_q <= 1'b0;
						if (!rxd && rzero_q)
							brk_seen_q <= 1'b1;
					end else
						rsh_q <= ctrl_q[`CTRL_BITS7] ?
							{1'b0, rxd, rsh_q[6:1]} : {rxd, rsh_q[7:1]};
				end
			end
			if (rf_push && ctrl_q[`CTRL_XONXOFF]) begin
				if (rf_wdata == xoff_q)
					xoff_hold_q <= 1'b1;
				else if (rf_wdata == xon_q)
					xoff_hold_q <= 1'b0;
			end
		end
	end
	wire rx_done = rbusy_q & tick16_q & (rdiv_q == 4'h7) &
		(rbit_q == tlast) & rxd;

	// ---------------------------------------------------------------
	// Bit-bang engine
	// ---------------------------------------------------------------
	reg [2:0]  bb_wr_q, bb_rd_q;
	wire       bb_mode = (mode == `MODE_ABB) | (mode == `MODE_SBB);
	reg [3:0]  bb_cnt_q;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bb_out_q <= 8'h00;
			bb_cnt_q <= 4'h0;
			bb_wr_q  <= 3'h0;
			bb_rd_q  <= 3'h0;
		end else begin
			bb_wr_q <= {bb_wr_q[1:0], 1'b0};
			bb_rd_q <= {bb_rd_q[1:0], 1'b0};
			if (bb_mode && tick16_q)
				bb_cnt_q <= bb_cnt_q + 4'h1;
			if (bb_mode && hf_pop) begin
				bb_out_q <= hf_data;
				bb_wr_q  <= 3'h7;
			end
			if (bb_mode && rf_push)
				bb_rd_q <= 3'h7;
		end
	end
	wire bb_slot = bb_mode & tick16_q & (bb_cnt_q == 4'hf);

	// FIFO movers
	always @* begin
		hf_pop   = 1'b0;
		rf_push  = 1'b0;
		rf_wdata = rsh_q;
		case (mode)
		`MODE_UART: begin
			hf_pop  = hf_valid & ~tbusy_q & tx_allowed & tick16_q;
			rf_push = rx_done & rf_ready;
		end
		`MODE_ABB: begin
			hf_pop   = hf_valid & bb_slot;
			rf_push  = bb_slot & rf_ready;
			rf_wdata = pins;
		end
		`MODE_SBB: begin
			hf_pop   = hf_valid & bb_slot & rf_ready;
			rf_push  = hf_pop;
			rf_wdata = pins;
		end
		default: ;
		endcase
	end

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	wire txd = tsh_q[0] & ~ctrl_q[`CTRL_BREAK];
	wire rts_out = ctrl_q[`CTRL_RTSCTS] ? ~rts_q : ~ctrl_q[`CTRL_RTS];
	wire [7:0] uart_out = {2'b00, 1'b0, ~ctrl_q[`CTRL_DTR], 1'b0,
		rts_out, 1'b1, txd};
	assign port_out = (bb_mode ? bb_out_q : uart_out) ^ invert_q;
	assign port_oe  = bb_mode ? 8'hff : UART_OE;

	// ---------------------------------------------------------------
	// Configurable pins, clocks and suspend
	// ---------------------------------------------------------------
	reg       sof_tgl_q;
	reg [4:0] clkdiv_q;
	integer   i;
	assign keep_awake = (pincfg_q[2:0]  == `PIN_KEEPAWAKE && !cfg_s2_q[0]) |
		(pincfg_q[5:3]  == `PIN_KEEPAWAKE && !cfg_s2_q[1]) |
		(pincfg_q[8:6]  == `PIN_KEEPAWAKE && !cfg_s2_q[2]) |
		(pincfg_q[11:9] == `PIN_KEEPAWAKE && !cfg_s2_q[3]);
	assign suspend_active = usb_suspend & ~keep_awake;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sof_tgl_q <= 1'b0;
			clkdiv_q  <= 5'h00;
		end else begin
			if (sof_pulse)
				sof_tgl_q <= ~sof_tgl_q;
			if (!suspend_active && tick48)
				clkdiv_q <= clkdiv_q + 5'h01;
		end
	end
	always @* begin
		config_pins_out = 4'h0;
		config_pins_oe  = 4'h0;
		for (i = 0; i < 4; i = i + 1) begin
			config_pins_oe[i] = 1'b1;
			case (pincfg_q[3*i +: 3])
			`PIN_LINE_DRIVER_ENABLE: config_pins_out[i] = tbusy_q;
			`PIN_WRSTB: config_pins_out[i] = ~bb_wr_q[2];
			`PIN_RDSTB: config_pins_out[i] = ~bb_rd_q[2];
			`PIN_SOF:   config_pins_out[i] = sof_tgl_q;
			`PIN_SLEEP: config_pins_out[i] = ~suspend_active;
			`PIN_CLK6:  config_pins_out[i] = clkdiv_q[2];
			default:    config_pins_oe[i]  = 1'b0;
			endcase
		end
	end
endmodule
